// *** design/sdpd_pkg.sv ***
// Shared constants and types for the SDRAM power-down sequencer.
package sdpd_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timer widths
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 50000;
  localparam int TMR_W         = 16;
  localparam int CFG_W         = 8;

  // ---------------------------------------------------------------------------
  // Timing figures in their own units
  // ---------------------------------------------------------------------------
  localparam int EXIT_DELAY_NCK      = 4;
  localparam int EXIT_DELAY_PS       = 6000;
  localparam int CKE_WIDTH_NCK       = 3;
  localparam int CKE_WIDTH_PS        = 5000;
  localparam int CMD_PATH_DIS_NCK    = 4;
  localparam int STABLE_CLK_NCK      = 5;
  localparam int STABLE_CLK_PS       = 10000;
  localparam int ACT_TO_PD_NCK       = 2;
  localparam int PRE_TO_PD_NCK       = 2;
  localparam int REF_TO_PD_NCK       = 1;
  localparam int RD_TO_PD_EXTRA_NCK  = 5;
  localparam int WR_BL8_EXTRA_NCK    = 4;
  localparam int WR_BC4_EXTRA_NCK    = 2;
  localparam int WRA_EXTRA_NCK       = 1;
  localparam int TERM_DELAY_MAX_PS   = 9000;
  localparam int RESIDENCY_REFI_MULT = 9;
  localparam int REFI_DEFAULT_NS     = 7800;

  // Least times round up, never below one cycle; nCK floor taken as larger.
  function automatic int min_cycles(input int nck, input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    if (c < 1) c = 1;
    return (c > nck) ? c : nck;
  endfunction : min_cycles

  // Longest times round down, never below one cycle.
  function automatic int max_cycles(input int ps);
    int c;
    c = ps / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : max_cycles

  localparam int EXIT_DELAY_CYC = min_cycles(EXIT_DELAY_NCK, EXIT_DELAY_PS);
  localparam int CKE_WIDTH_CYC  = min_cycles(CKE_WIDTH_NCK, CKE_WIDTH_PS);
  localparam int STABLE_CLK_CYC = min_cycles(STABLE_CLK_NCK, STABLE_CLK_PS);
  localparam int TERM_WAIT_CYC  = min_cycles(1, TERM_DELAY_MAX_PS);

  // ---------------------------------------------------------------------------
  // Command codes and sequencer states
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_DES, CMD_ACT, CMD_PRE, CMD_PREA, CMD_RD, CMD_RDA,
    CMD_WR, CMD_WRA, CMD_REF, CMD_MRS
  } sdpd_cmd_t;

  typedef enum logic [2:0] {
    ST_ACTIVE, ST_PD_ENTRY, ST_PD, ST_CLK_WAKE, ST_EXIT
  } sdpd_state_t;

endpackage : sdpd_pkg

// *** design/sdpd_timer.sv ***
// Down-counting spacing timer that only ever extends its remaining wait.
`timescale 1ns/1ns
module sdpd_timer #(
  parameter int W = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         srst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              done
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_dec;

  assign cnt_dec = (cnt_q != '0) ? cnt_q - W'(1) : '0;
  assign done    = (cnt_q == '0);

  // A new load never shortens a wait already running.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_q <= '0;
    end else if (load && (load_val > cnt_dec)) begin
      cnt_q <= load_val;
    end else begin
      cnt_q <= cnt_dec;
    end
  end

endmodule : sdpd_timer

// *** design/sdpd_ctrl.sv ***
// Controller side of SDRAM power-down: entry spacing, CKE timing, exit and ODT.
`timescale 1ns/1ns
module sdpd_ctrl
  import sdpd_pkg::*;
#(
  parameter int REFI_NS = sdpd_pkg::REFI_DEFAULT_NS
) (
  input  wire logic                       clk_sys,
  input  wire logic                       srst,
  input  wire logic                       cmd_valid,
  input  wire sdpd_pkg::sdpd_cmd_t        cmd_code,
  output logic                            cmd_ready,
  input  wire logic                       pd_enter_req,
  input  wire logic                       pd_exit_req,
  input  wire logic                       odt_req,
  input  wire logic [sdpd_pkg::CFG_W-1:0] read_latency,
  input  wire logic [sdpd_pkg::CFG_W-1:0] write_latency,
  input  wire logic [sdpd_pkg::CFG_W-1:0] write_recovery_ns,
  input  wire logic [sdpd_pkg::CFG_W-1:0] write_recovery_cyc,
  input  wire logic [sdpd_pkg::CFG_W-1:0] mode_update_delay,
  input  wire logic                       burst_chop_fixed,
  output logic                            mem_cke,
  output sdpd_pkg::sdpd_cmd_t             mem_cmd,
  output logic                            mem_clk_run,
  output logic                            mem_odt,
  output logic                            odt_settled,
  output logic                            pd_active
);
  import sdpd_pkg::*;

  // ---------------------------------------------------------------------------
  // Derived counts
  // ---------------------------------------------------------------------------
  localparam int RESIDENCY_CYC = (RESIDENCY_REFI_MULT * REFI_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [TMR_W-1:0] PERIOD_NS = TMR_W'(CLK_PERIOD_PS / 1000);

  sdpd_state_t      state_q;
  logic             cmd_ready_q;
  logic             mem_cke_q;
  sdpd_cmd_t        mem_cmd_q;
  logic             mem_clk_run_q;
  logic             mem_odt_q;
  logic             odt_settled_q;
  logic             pd_active_q;
  logic             cmd_fire;
  logic             enter_go;
  logic             exit_want;
  logic [TMR_W-1:0] twr_cyc;
  logic [TMR_W-1:0] wr_extra;
  logic [TMR_W-1:0] entry_need;
  logic             entry_load;
  logic             entry_done;
  logic             cke_done;
  logic             stage_done;
  logic             stage_load;
  logic [TMR_W-1:0] stage_val;
  logic             res_done;
  logic             odt_done;
  logic             cke_flip;
  logic             wake_go;
  logic             exit_done;

  assign cmd_ready   = cmd_ready_q;
  assign mem_cke     = mem_cke_q;
  assign mem_cmd     = mem_cmd_q;
  assign mem_clk_run = mem_clk_run_q;
  assign mem_odt     = mem_odt_q;
  assign odt_settled = odt_settled_q;
  assign pd_active   = pd_active_q;

  assign cmd_fire = cmd_valid && cmd_ready_q && (state_q == ST_ACTIVE);

  // ---------------------------------------------------------------------------
  // Spacing from the last command to power-down entry
  // ---------------------------------------------------------------------------
  assign twr_cyc  = (TMR_W'(write_recovery_ns) + PERIOD_NS - TMR_W'(1)) / PERIOD_NS;
  assign wr_extra = burst_chop_fixed ? TMR_W'(WR_BC4_EXTRA_NCK) : TMR_W'(WR_BL8_EXTRA_NCK);

  always_comb begin
    entry_need = '0;
    entry_load = cmd_fire;
    case (cmd_code)
      CMD_ACT:  entry_need = TMR_W'(ACT_TO_PD_NCK);
      CMD_PRE,
      CMD_PREA: entry_need = TMR_W'(PRE_TO_PD_NCK);
      CMD_RD,
      CMD_RDA:  entry_need = TMR_W'(read_latency) + TMR_W'(RD_TO_PD_EXTRA_NCK);
      CMD_WR:   entry_need = TMR_W'(write_latency) + wr_extra + twr_cyc;
      CMD_WRA:  entry_need = TMR_W'(write_latency) + wr_extra
                           + TMR_W'(write_recovery_cyc) + TMR_W'(WRA_EXTRA_NCK);
      CMD_REF:  entry_need = TMR_W'(REF_TO_PD_NCK);
      CMD_MRS:  entry_need = TMR_W'(mode_update_delay);
      default:  entry_need = '0;
    endcase
  end

  // Only command-to-entry spacing and the CKE high width gate entry; device-internal
  // activity may still be running when CKE falls.
  sdpd_timer #(.W(TMR_W)) u_entry_tmr (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .load     (entry_load),
    .load_val (entry_need),
    .done     (entry_done)
  );

  // ---------------------------------------------------------------------------
  // CKE level width
  // ---------------------------------------------------------------------------
  sdpd_timer #(.W(TMR_W)) u_cke_tmr (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .load     (cke_flip),
    .load_val (TMR_W'(CKE_WIDTH_CYC - 1)),
    .done     (cke_done)
  );

  // ---------------------------------------------------------------------------
  // Stage timer: command-path disable, clock stable before exit, exit delay
  // ---------------------------------------------------------------------------
  sdpd_timer #(.W(TMR_W)) u_stage_tmr (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .load     (stage_load),
    .load_val (stage_val),
    .done     (stage_done)
  );

  // ---------------------------------------------------------------------------
  // Residency limit
  // ---------------------------------------------------------------------------
  sdpd_timer #(.W(TMR_W)) u_res_tmr (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .load     (enter_go),
    .load_val (TMR_W'(RESIDENCY_CYC - STABLE_CLK_CYC - 1)),
    .done     (res_done)
  );

  // ---------------------------------------------------------------------------
  // Sequencer decisions
  // ---------------------------------------------------------------------------
  assign enter_go = (state_q == ST_ACTIVE) && pd_enter_req && !cmd_fire
                    && entry_done && cke_done;
  // Leaving is allowed after the least width, and forced at the limit.
  assign exit_want = (state_q == ST_PD) && cke_done && stage_done
                     && (pd_exit_req || res_done);
  assign cke_flip  = enter_go || wake_go;
  assign wake_go   = (state_q == ST_CLK_WAKE) && stage_done;
  assign exit_done = (state_q == ST_EXIT) && stage_done && cke_done;

  always_comb begin
    stage_load = 1'b0;
    stage_val  = '0;
    if (enter_go) begin
      stage_load = 1'b1;
      stage_val  = TMR_W'(CMD_PATH_DIS_NCK - 1);
    end else if (exit_want) begin
      stage_load = 1'b1;
      stage_val  = TMR_W'(STABLE_CLK_CYC - 1);
    end else if (wake_go) begin
      stage_load = 1'b1;
      stage_val  = TMR_W'(EXIT_DELAY_CYC - 1);
    end
  end

  // ---------------------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= ST_ACTIVE;
    end else begin
      case (state_q)
        ST_ACTIVE: begin
          if (enter_go) begin
            state_q <= ST_PD_ENTRY;
          end
        end
        ST_PD_ENTRY: begin
          if (stage_done) begin
            state_q <= ST_PD;
          end
        end
        ST_PD: begin
          if (exit_want) begin
            state_q <= ST_CLK_WAKE;
          end
        end
        ST_CLK_WAKE: begin
          if (wake_go) begin
            state_q <= ST_EXIT;
          end
        end
        ST_EXIT: begin
          if (exit_done) begin
            state_q <= ST_ACTIVE;
          end
        end
        default: begin
          state_q <= ST_ACTIVE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Clock enable
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mem_cke_q <= 1'b1;
    end else if (enter_go) begin
      mem_cke_q <= 1'b0;
    end else if (wake_go) begin
      mem_cke_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Memory clock: stopped while resident, restarted ahead of the CKE rise
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mem_clk_run_q <= 1'b1;
    end else if (state_q == ST_PD) begin
      mem_clk_run_q <= exit_want;
    end
  end

  // ---------------------------------------------------------------------------
  // Status and command acceptance
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pd_active_q <= 1'b0;
    end else if (enter_go) begin
      pd_active_q <= 1'b1;
    end else if (exit_done) begin
      pd_active_q <= 1'b0;
    end
  end

  // Commands are refused from the entry edge until the exit delay has run out.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cmd_ready_q <= 1'b0;
    end else if (enter_go) begin
      cmd_ready_q <= 1'b0;
    end else if ((state_q == ST_ACTIVE) || exit_done) begin
      cmd_ready_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Command bus: deselect whenever no command is taken
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mem_cmd_q <= CMD_DES;
    end else if (cmd_fire && !enter_go) begin
      mem_cmd_q <= cmd_code;
    end else begin
      mem_cmd_q <= CMD_DES;
    end
  end

  // ---------------------------------------------------------------------------
  // Termination: wait out the longest asynchronous switch time
  // ---------------------------------------------------------------------------
  sdpd_timer #(.W(TMR_W)) u_odt_tmr (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .load     (odt_req != mem_odt_q),
    .load_val (TMR_W'(TERM_WAIT_CYC)),
    .done     (odt_done)
  );

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mem_odt_q     <= 1'b0;
      odt_settled_q <= 1'b1;
    end else begin
      mem_odt_q     <= odt_req;
      odt_settled_q <= odt_done && (odt_req == mem_odt_q);
    end
  end

endmodule : sdpd_ctrl

// *** dv/sdpd_ctrl_props.sv ***
// Port-level timing properties of the SDRAM power-down sequencer.
`timescale 1ns/1ns
module sdpd_ctrl_props
  import sdpd_pkg::*;
#(
  parameter int REFI_NS = REFI_DEFAULT_NS
) (
  input wire logic                       clk_sys,
  input wire logic                       srst,
  input wire logic                       odt_req,
  input wire logic [sdpd_pkg::CFG_W-1:0] read_latency,
  input wire logic [sdpd_pkg::CFG_W-1:0] write_latency,
  input wire logic [sdpd_pkg::CFG_W-1:0] write_recovery_ns,
  input wire logic [sdpd_pkg::CFG_W-1:0] write_recovery_cyc,
  input wire logic [sdpd_pkg::CFG_W-1:0] mode_update_delay,
  input wire logic                       burst_chop_fixed,
  input wire logic                       cmd_ready,
  input wire logic                       mem_cke,
  input wire sdpd_pkg::sdpd_cmd_t        mem_cmd,
  input wire logic                       mem_clk_run,
  input wire logic                       mem_odt,
  input wire logic                       odt_settled
);
  localparam int LIM = 9 * REFI_NS * 1000 / CLK_PERIOD_PS;
  int rem_q;
  int low_q;
  int run_q;
  // Cycles that a command on the memory bus bars the CKE fall of power-down entry.
  function automatic int need(input sdpd_cmd_t c);
    case (c)
      CMD_ACT, CMD_PRE, CMD_PREA: return 2;
      CMD_RD, CMD_RDA: return read_latency + 5;
      CMD_WR: return write_latency + (burst_chop_fixed ? 2 : 4)
                     + (write_recovery_ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      CMD_WRA: return write_latency + write_recovery_cyc + (burst_chop_fixed ? 3 : 5);
      CMD_REF: return 1;
      CMD_MRS: return mode_update_delay;
      default: return 0;
    endcase
  endfunction : need
  always_ff @(posedge clk_sys) begin
    if (srst) rem_q <= 0;
    else if (need(mem_cmd) > rem_q) rem_q <= need(mem_cmd) - 1;
    else if (rem_q > 0) rem_q <= rem_q - 1;
  end
  always_ff @(posedge clk_sys) low_q <= (srst || mem_cke) ? 0 : low_q + 1;
  always_ff @(posedge clk_sys) run_q <= (srst || !mem_clk_run) ? 0 : run_q + 1;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  cmd_gate_a: assert property (mem_cmd != CMD_DES |-> $past(cmd_ready))
    else $error("command issued while not ready");
  pd_deselect_a: assert property (!mem_cke |-> mem_cmd == CMD_DES)
    else $error("command while clock enable low");
  cke_low_width_a: assert property ($fell(mem_cke) |-> !mem_cke [*4])
    else $error("clock enable low too short");
  cke_high_width_a: assert property ($rose(mem_cke) |-> mem_cke [*3])
    else $error("clock enable high too short");
  clk_stable_a: assert property ($rose(mem_cke) |-> run_q >= STABLE_CLK_CYC)
    else $error("clock not running before exit");
  exit_delay_a: assert property ($rose(mem_cke) |-> (!cmd_ready && mem_cmd == CMD_DES) [*4])
    else $error("command too soon after exit");
  entry_space_a: assert property ($fell(mem_cke) |-> rem_q == 0)
    else $error("entry too soon after command");
  residency_max_a: assert property (!mem_cke |-> low_q < LIM)
    else $error("power-down held too long");
  odt_follow_a: assert property ($changed(odt_req) |=> mem_odt == $past(odt_req))
    else $error("termination did not follow request");
  odt_settle_a: assert property ($changed(mem_odt) |-> ##[1:3] odt_settled)
    else $error("termination never settled");
  cover property ($fell(mem_cke));
  cover property ($rose(mem_cke));
  cover property (mem_cmd == CMD_WRA && burst_chop_fixed);
  cover property ($rose(mem_clk_run));
endmodule : sdpd_ctrl_props
bind sdpd_ctrl sdpd_ctrl_props #(.REFI_NS(REFI_NS)) sdpd_ctrl_props_i (.clk_sys, .srst, .odt_req,
  .read_latency, .write_latency, .write_recovery_ns, .write_recovery_cyc, .mode_update_delay,
  .burst_chop_fixed, .cmd_ready, .mem_cke, .mem_cmd, .mem_clk_run, .mem_odt, .odt_settled);

// *** dv/sdpd_mem_model.sv ***
// Behavioural DRAM side that obeys clock enable and counts controller timing faults.
`timescale 1ns/1ns
module sdpd_mem_model
  import sdpd_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                srst,
  input  wire logic                mem_cke,
  input  wire sdpd_pkg::sdpd_cmd_t mem_cmd,
  input  wire logic                mem_clk_run,
  input  wire logic                mem_odt,
  output logic                     in_pd,
  output logic                     term_on,
  output int                       err
);
  logic cke_q;
  int   held_q;
  int   run_q;
  int   up_q;
  always @(mem_odt) term_on <= #5 mem_odt;
  always @(posedge clk_sys) begin
    run_q <= mem_clk_run ? run_q + 1 : 0;
    if (srst) begin
      cke_q  <= 1'b1;
      in_pd  <= 1'b0;
      held_q <= 9;
      up_q   <= 9;
      err    <= 0;
    end else if (mem_clk_run) begin
      held_q <= (mem_cke != cke_q) ? 1 : held_q + 1;
      up_q   <= (mem_cke && !cke_q) ? 1 : up_q + 1;
      cke_q  <= mem_cke;
      in_pd  <= !mem_cke;
      if (mem_cke != cke_q && held_q < CKE_WIDTH_CYC) err <= err + 1;
      if (mem_cke && !cke_q && run_q < STABLE_CLK_CYC) err <= err + 1;
      if (mem_cmd != CMD_DES && (!mem_cke || !cke_q || up_q < EXIT_DELAY_CYC)) err <= err + 1;
    end else if (mem_cke != cke_q) err <= err + 1;
  end
endmodule : sdpd_mem_model

// *** dv/tb.sv ***
// Self-checking bench for the power-down sequencer against the DRAM model.
`timescale 1ns/1ns
module tb;
  import sdpd_pkg::*;
  localparam int         REFI = 100;
  localparam logic [7:0] RL = 8'h0B, WL = 8'h09, WRNS = 8'h3C, WRC = 8'h0C, MUD = 8'h18;
  logic      clk_sys = 0, srst = 1, cmd_valid = 0, pd_enter_req = 0, pd_exit_req = 0;
  logic      odt_req = 0, chop = 0;
  sdpd_cmd_t cmd_code = CMD_DES, mem_cmd;
  logic      cmd_ready, mem_cke, mem_clk_run, mem_odt, odt_settled, pd_active, in_pd, term_on;
  int        miscompares = 0, n_checks = 0, cyc = 0, err;
  sdpd_ctrl #(.REFI_NS(REFI)) sdpd_ctrl_i (.clk_sys, .srst, .cmd_valid, .cmd_code, .cmd_ready,
    .pd_enter_req, .pd_exit_req, .odt_req, .read_latency(RL), .write_latency(WL),
    .write_recovery_ns(WRNS), .write_recovery_cyc(WRC), .mode_update_delay(MUD),
    .burst_chop_fixed(chop), .mem_cke, .mem_cmd, .mem_clk_run, .mem_odt, .odt_settled, .pd_active);
  sdpd_mem_model sdpd_mem_model_i (.clk_sys, .srst, .mem_cke, .mem_cmd, .mem_clk_run, .mem_odt,
    .in_pd, .term_on, .err);
  always #25 clk_sys = ~clk_sys;
  // The write term of 2 is 60 ns of recovery rounded up to whole 50 ns cycles.
  function automatic int need(input sdpd_cmd_t c);
    case (c)
      CMD_ACT, CMD_PRE, CMD_PREA: return 2;
      CMD_RD, CMD_RDA: return RL + 5;
      CMD_WR: return WL + (chop ? 2 : 4) + 2;
      CMD_WRA: return WL + WRC + (chop ? 3 : 5);
      CMD_REF: return 1;
      CMD_MRS: return MUD;
      default: return 0;
    endcase
  endfunction : need
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  task automatic wait_cke(input logic v, output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (mem_cke !== v && n < 400);
  endtask : wait_cke
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (cmd_ready !== 1'b1 && n < 400);
    check(n >= EXIT_DELAY_CYC && n < 400, 1'b1);
  endtask : wait_ready
  task automatic send(input sdpd_cmd_t c);
    int k;
    cmd_valid <= 1'b1;
    cmd_code  <= c;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (cmd_ready !== 1'b1 && k < 400);
    cmd_valid <= 1'b0;
    @(posedge clk_sys);
    check(mem_cmd, c);
  endtask : send
  task automatic wake();
    int n;
    pd_exit_req <= 1'b1;
    wait_cke(1'b1, n);
    pd_exit_req <= 1'b0;
    check(n >= CMD_PATH_DIS_NCK && n < 400, 1'b1);
    wait_ready();
  endtask : wake
  task automatic pd_after(input sdpd_cmd_t c, input int nd);
    int n;
    pd_enter_req <= 1'b1;
    send(c);
    wait_cke(1'b0, n);
    pd_enter_req <= 1'b0;
    check(n >= nd && n <= nd + 3, 1'b1);
    check(pd_active, 1'b1);
    wake();
  endtask : pd_after
  task automatic t_spacing();
    for (int i = 1; i < 10; i++) begin
      pd_after(sdpd_cmd_t'(i), need(sdpd_cmd_t'(i)));
    end
  endtask : t_spacing
  task automatic t_back();
    send(CMD_WR);
    pd_after(CMD_ACT, need(CMD_WR) - 2);
  endtask : t_back
  task automatic t_chop();
    chop <= 1'b1;
    @(posedge clk_sys);
    pd_after(CMD_WR, need(CMD_WR));
    pd_after(CMD_WRA, need(CMD_WRA));
    chop <= 1'b0;
  endtask : t_chop
  task automatic t_resid();
    int n;
    pd_enter_req <= 1'b1;
    wait_cke(1'b0, n);
    pd_enter_req <= 1'b0;
    wait_cke(1'b1, n);
    check(n <= 9 * REFI * 1000 / CLK_PERIOD_PS && n >= CKE_WIDTH_CYC, 1'b1);
    wait_ready();
  endtask : t_resid
  task automatic t_odt();
    int n;
    for (int i = 0; i < 2; i++) begin
      if (i == 1) begin
        pd_enter_req <= 1'b1;
        wait_cke(1'b0, n);
        pd_enter_req <= 1'b0;
      end
      odt_req <= ~odt_req;
      repeat (2) @(posedge clk_sys);
      check({in_pd, mem_odt}, {i[0], odt_req});
      repeat (4) @(posedge clk_sys);
      check({odt_settled, term_on}, {1'b1, odt_req});
    end
    wake();
  endtask : t_odt
  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t_spacing();
    t_back();
    t_chop();
    t_resid();
    t_odt();
    check(err, 0);
    results();
  end
endmodule : tb
